// *** hw/tdmch_defines.svh ***
`ifndef TDMCH_DEFINES_SVH
`define TDMCH_DEFINES_SVH

// ----------------------------------------------------------------------
// Frame layout inside one 32-bit channel, bit 0 sent first, MSB first
// ----------------------------------------------------------------------
`define TDMCH_MON_FIRST   5'd16
`define TDMCH_MON_LAST    5'd23
`define TDMCH_BA_BIT      5'd20
`define TDMCH_ADDR_FIRST  5'd21
`define TDMCH_CI_FIRST    5'd26
`define TDMCH_CI_LAST     5'd29
`define TDMCH_E_BIT       5'd31
`define TDMCH_FX_NIBBLE   4'hf

// ----------------------------------------------------------------------
// Command codes on the user port
// ----------------------------------------------------------------------
`define TDMCH_CMD_CI      2'h0
`define TDMCH_CMD_ANSWER  2'h1
`define TDMCH_CMD_CFG     2'h2

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define TDMCH_ADDR_RST    3'h7
`define TDMCH_CI_RST      4'hf
`define TDMCH_MON_RST     8'hff
`define TDMCH_FREE_FRAMES 2'h2

`endif

// *** hw/tdmch_pkg.sv ***
`default_nettype none

package tdmch_pkg;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ARB_IDLE, ARB_CONTEND, ARB_HOLD} tdmch_arb_t;
    typedef enum logic [1:0] {ANS_IDLE, ANS_EFRAME, ANS_SEND} tdmch_ans_t;

    typedef struct packed {
        logic [7:0] bitCnt;
        logic       muxMode;
        logic [2:0] chanSel;
        logic [2:0] addr;
        tdmch_arb_t arb;
        logic [1:0] freeCnt;
        logic       lowPrio;
        logic       held;
        logic [3:0] ciTx;
        tdmch_ans_t ans;
        logic [7:0] ansByte;
        logic       ackTgl;
        logic [7:0] monShift;
        logic       ownMon;
        logic [7:0] monRx;
        logic       monTgl;
        logic [3:0] ciShift;
        logic [3:0] ciLast;
        logic [3:0] ciRx;
        logic       ciTgl;
        logic       stopGo;
        logic       upOe;
    } tdmch_lk_t;

    typedef struct packed {
        logic       busReq;
        logic       reqTgl;
        logic [1:0] cmdKind;
        logic [7:0] cmdData;
        logic       cmdReady;
        logic       cmdReject;
        logic       ackSeen;
        logic       ciSeen;
        logic       monSeen;
        logic       ciChange;
        logic       monRxValid;
        logic [3:0] ciRx;
        logic [7:0] monRx;
        logic       busHeld;
        logic       stopGo;
    } tdmch_us_t;

endpackage

`default_nettype wire

// *** hw/tdmch_sync2.sv ***
`default_nettype none

module tdmch_sync2 #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk,
    // Level from the other domain
    input  wire logic [W-1:0] din,
    // Synchronised level
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tdmch_sync_t;

    tdmch_sync_t st_ff;
    tdmch_sync_t nxt_st;

    // The first stage feeds only the second one.
    always_comb begin
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign q = st_ff.s2;

endmodule // tdmch_sync2

`default_nettype wire

// *** hw/tdmch_host.sv ***
`default_nettype none
`include "tdmch_defines.svh"

// Contract
// - One monitor byte per exchange, never a multi-byte transfer.
// - Never send a monitor byte whose upper nibble is all ones.
// - An answering peer drives E low, then sends its byte next frame.
// - Up to seven controllers share upstream wired-AND, read downstream.
// - Error-free address wins; lowest address wins among contenders.
// - With no requester the address reads 7, owner of default access.
// - Bus request is withdrawn once the command channel is not needed.
// - Channel: B1, B2, monitor, then D, command/indicate and handshake.
// - Multiplexed mode has eight channels; a three-bit field selects one.
// - Terminal mode has three channels; channel 2 serves arbitration only. The code arbitrates in the selected channel 0 or 1 instead.
module tdmch_host
    import tdmch_pkg::*;
(
    // System clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Link pins
    input  wire logic       linkDataClock,
    input  wire logic       frameSync,
    input  wire logic       downstreamLine,
    input  wire logic       upstreamLineIn,
    output logic            upstreamLineOut,
    output logic            upstreamLineOe,
    // Command port
    input  wire logic       cmdValid,
    input  wire logic [1:0] cmdKind,
    input  wire logic [7:0] cmdData,
    output logic            cmdReady,
    output logic            cmdReject,
    // Bus request and status
    input  wire logic       busRequest,
    output logic            busHeld,
    output logic            stopGo,
    // Received channel data
    output logic [3:0]      ciRx,
    output logic            ciChange,
    output logic [7:0]      monRx,
    output logic            monRxValid
);

    // ------------------------------------------------------------------
    // Crossings
    // ------------------------------------------------------------------
    tdmch_lk_t  lk_ff;
    tdmch_lk_t  nxt_lk;
    tdmch_us_t  us_ff;
    tdmch_us_t  nxt_us;
    logic [2:0] toLink;
    logic [4:0] toUser;
    logic       lkRst;
    logic       busReqS;
    logic       reqS;

    // Command fields are held in the user register until acknowledged,
    // so the link side may read them once the toggle has crossed.
    tdmch_sync2 #(.W(3)) u_sync_link (
        .clk (linkDataClock),
        .din ({rst, us_ff.busReq, us_ff.reqTgl}),
        .q   (toLink)
    );

    tdmch_sync2 #(.W(5)) u_sync_user (
        .clk (ref_clk),
        .din ({lk_ff.ackTgl, lk_ff.ciTgl, lk_ff.monTgl, lk_ff.held,
               lk_ff.stopGo}),
        .q   (toUser)
    );

    assign lkRst   = toLink[2];
    assign busReqS = toLink[1];
    assign reqS    = toLink[0];

    // ------------------------------------------------------------------
    // Link position
    // ------------------------------------------------------------------
    logic [2:0] effChan;
    logic [7:0] base;
    logic [7:0] rel;
    logic       inCh;
    logic [4:0] r;
    logic [7:0] nxtCnt;
    logic [7:0] nRel;
    logic       nIn;
    logic [4:0] nr;
    logic [4:0] dIdx;
    logic [4:0] cIdx;
    logic [4:0] aIdx;
    logic [3:0] ciCode;
    logic [7:0] monByte;
    logic       mism;

    // In terminal mode channel 2 carries no monitor, so only 0 or 1 is used.
    assign effChan = lk_ff.muxMode ? lk_ff.chanSel
                                   : {2'b00, lk_ff.chanSel[0]};
    assign base    = {effChan, 5'h00};
    assign rel     = lk_ff.bitCnt - base;
    assign inCh    = (rel[7:5] == 3'h0);
    assign r       = rel[4:0];
    assign nxtCnt  = frameSync ? 8'h00 : 8'(lk_ff.bitCnt + 8'h01);
    assign nRel    = nxtCnt - base;
    assign nIn     = (nRel[7:5] == 3'h0);
    assign nr      = nRel[4:0];
    assign dIdx    = `TDMCH_MON_LAST - nr;
    assign cIdx    = `TDMCH_CI_LAST - nr;
    assign aIdx    = `TDMCH_MON_LAST - r;
    assign ciCode  = {lk_ff.ciShift[2:0], downstreamLine};
    assign monByte = {lk_ff.monShift[6:0], upstreamLineIn};
    assign mism    = (upstreamLineIn != lk_ff.addr[aIdx[1:0]]);

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    always_comb begin
        nxt_lk = lk_ff;
        if (reqS != lk_ff.ackTgl) begin
            unique case (us_ff.cmdKind)
                `TDMCH_CMD_CI: begin
                    nxt_lk.ciTx   = us_ff.cmdData[3:0];
                    nxt_lk.ackTgl = reqS;
                end
                `TDMCH_CMD_CFG: begin
                    nxt_lk.muxMode = us_ff.cmdData[6];
                    nxt_lk.chanSel = us_ff.cmdData[5:3];
                    nxt_lk.addr    = us_ff.cmdData[2:0];
                    nxt_lk.ackTgl  = reqS;
                end
                `TDMCH_CMD_ANSWER: begin
                    // A second answer waits until the first has gone out.
                    if (lk_ff.ans == ANS_IDLE && lk_ff.arb == ARB_IDLE) begin
                        nxt_lk.ansByte = us_ff.cmdData;
                        nxt_lk.ans     = ANS_EFRAME;
                        nxt_lk.ackTgl  = reqS;
                    end
                end
                default: nxt_lk.ackTgl = reqS;
            endcase
        end
        if (inCh) begin
            if (r >= `TDMCH_MON_FIRST && r <= `TDMCH_MON_LAST) begin
                nxt_lk.monShift = monByte;
                nxt_lk.ownMon   = lk_ff.ownMon | lk_ff.upOe;
            end
            if (r == `TDMCH_BA_BIT) begin
                nxt_lk.stopGo = downstreamLine;
                unique case (lk_ff.arb)
                    ARB_IDLE: begin
                        if (busReqS && !lk_ff.lowPrio && upstreamLineIn
                            && lk_ff.ans == ANS_IDLE) begin
                            nxt_lk.arb = ARB_CONTEND;
                        end
                    end
                    ARB_CONTEND: nxt_lk.arb = ARB_IDLE;
                    ARB_HOLD: begin
                        if (!busReqS) begin
                            nxt_lk.arb     = ARB_IDLE;
                            nxt_lk.lowPrio = 1'b1;
                            nxt_lk.freeCnt = 2'h0;
                        end
                    end
                endcase
                if (lk_ff.lowPrio) begin
                    if (!upstreamLineIn) begin
                        nxt_lk.freeCnt = 2'h0;
                    end else if (2'(lk_ff.freeCnt + 2'h1)
                                 == `TDMCH_FREE_FRAMES) begin
                        nxt_lk.lowPrio = 1'b0;
                    end else begin
                        nxt_lk.freeCnt = 2'(lk_ff.freeCnt + 2'h1);
                    end
                end
            end
            if (lk_ff.arb == ARB_CONTEND && r >= `TDMCH_ADDR_FIRST
                && r <= `TDMCH_MON_LAST) begin
                if (mism) begin
                    nxt_lk.arb = ARB_IDLE;
                end else if (r == `TDMCH_MON_LAST) begin
                    nxt_lk.arb = ARB_HOLD;
                end
            end
            if (r == `TDMCH_MON_LAST) begin
                // All-ones nibbles are idle or arbitration, never messages.
                if (!(lk_ff.ownMon | lk_ff.upOe)
                    && monByte[7:4] != `TDMCH_FX_NIBBLE) begin
                    nxt_lk.monRx  = monByte;
                    nxt_lk.monTgl = ~lk_ff.monTgl;
                end
                nxt_lk.ownMon = 1'b0;
                if (lk_ff.ans == ANS_SEND) begin
                    nxt_lk.ans = ANS_IDLE;
                end
            end
            if (r >= `TDMCH_CI_FIRST && r <= `TDMCH_CI_LAST) begin
                nxt_lk.ciShift = ciCode;
            end
            if (r == `TDMCH_CI_LAST) begin
                if (ciCode == lk_ff.ciLast && ciCode != lk_ff.ciRx) begin
                    nxt_lk.ciRx  = ciCode;
                    nxt_lk.ciTgl = ~lk_ff.ciTgl;
                end
                nxt_lk.ciLast = ciCode;
            end
            if (r == `TDMCH_E_BIT && lk_ff.ans == ANS_EFRAME
                && lk_ff.upOe) begin
                nxt_lk.ans = ANS_SEND;
            end
        end
        nxt_lk.held   = (nxt_lk.arb == ARB_HOLD);
        nxt_lk.bitCnt = nxtCnt;
        // Open drain: a zero is driven, a one is left to the pull-up.
        nxt_lk.upOe = 1'b0;
        if (nIn) begin
            if (nr >= `TDMCH_MON_FIRST && nr <= `TDMCH_MON_LAST
                && nxt_lk.ans == ANS_SEND) begin
                nxt_lk.upOe = ~nxt_lk.ansByte[dIdx[2:0]];
            end else if (nr == `TDMCH_BA_BIT && nxt_lk.arb == ARB_HOLD) begin
                nxt_lk.upOe = 1'b1;
            end else if (nr >= `TDMCH_ADDR_FIRST && nr <= `TDMCH_MON_LAST
                         && nxt_lk.arb == ARB_CONTEND) begin
                nxt_lk.upOe = ~nxt_lk.addr[dIdx[1:0]];
            end else if (nr >= `TDMCH_CI_FIRST && nr <= `TDMCH_CI_LAST
                         && nxt_lk.arb == ARB_HOLD) begin
                nxt_lk.upOe = ~nxt_lk.ciTx[cIdx[1:0]];
            end else if (nr == `TDMCH_E_BIT && nxt_lk.ans == ANS_EFRAME) begin
                nxt_lk.upOe = 1'b1;
            end
        end
    end

    always_ff @(posedge linkDataClock) begin
        if (lkRst) begin
            lk_ff        <= '0;
            lk_ff.addr   <= `TDMCH_ADDR_RST;
            lk_ff.ciTx   <= `TDMCH_CI_RST;
            lk_ff.ciLast <= `TDMCH_CI_RST;
            lk_ff.ciRx   <= `TDMCH_CI_RST;
            lk_ff.monRx  <= `TDMCH_MON_RST;
            lk_ff.ackTgl <= reqS;
        end else begin
            lk_ff <= nxt_lk;
        end
    end

    // ------------------------------------------------------------------
    // User domain
    // ------------------------------------------------------------------
    always_comb begin
        nxt_us            = us_ff;
        nxt_us.cmdReject  = 1'b0;
        nxt_us.ciChange   = 1'b0;
        nxt_us.monRxValid = 1'b0;
        nxt_us.busReq     = busRequest;
        nxt_us.busHeld    = toUser[1];
        nxt_us.stopGo     = toUser[0];
        nxt_us.ackSeen    = toUser[4];
        if (toUser[3] != us_ff.ciSeen) begin
            nxt_us.ciSeen   = toUser[3];
            nxt_us.ciChange = 1'b1;
            nxt_us.ciRx     = lk_ff.ciRx;
        end
        if (toUser[2] != us_ff.monSeen) begin
            nxt_us.monSeen    = toUser[2];
            nxt_us.monRxValid = 1'b1;
            nxt_us.monRx      = lk_ff.monRx;
        end
        if (cmdValid && us_ff.cmdReady) begin
            if (cmdKind == `TDMCH_CMD_ANSWER
                && cmdData[7:4] == `TDMCH_FX_NIBBLE) begin
                nxt_us.cmdReject = 1'b1;
            end else begin
                nxt_us.reqTgl  = ~us_ff.reqTgl;
                nxt_us.cmdKind = cmdKind;
                nxt_us.cmdData = cmdData;
            end
        end
        nxt_us.cmdReady = (nxt_us.reqTgl == nxt_us.ackSeen);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            us_ff       <= '0;
            us_ff.ciRx  <= `TDMCH_CI_RST;
            us_ff.monRx <= `TDMCH_MON_RST;
        end else begin
            us_ff <= nxt_us;
        end
    end

    assign upstreamLineOut = 1'b0;
    assign upstreamLineOe  = lk_ff.upOe;
    assign cmdReady        = us_ff.cmdReady;
    assign cmdReject       = us_ff.cmdReject;
    assign busHeld         = us_ff.busHeld;
    assign stopGo          = us_ff.stopGo;
    assign ciRx            = us_ff.ciRx;
    assign ciChange        = us_ff.ciChange;
    assign monRx           = us_ff.monRx;
    assign monRxValid      = us_ff.monRxValid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_fx_never_sent: assert property (@(posedge linkDataClock)
        disable iff (lkRst) lk_ff.ans != ANS_IDLE
        |-> lk_ff.ansByte[7:4] != `TDMCH_FX_NIBBLE)
        else $error("reserved monitor byte queued");
    chk_e_then_byte: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (lk_ff.ans == ANS_EFRAME && lk_ff.upOe && inCh)
        |=> lk_ff.ans == ANS_SEND)
        else $error("answer byte not armed after E low");
    chk_oe_in_chan: assert property (@(posedge linkDataClock)
        disable iff (lkRst) lk_ff.upOe |-> inCh)
        else $error("upstream driven outside selected channel");
    chk_hold_flag_low: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (lk_ff.arb == ARB_HOLD && inCh
        && r == `TDMCH_BA_BIT && lk_ff.muxMode == $past(lk_ff.muxMode))
        |-> lk_ff.upOe)
        else $error("bus flag not held low while owning bus");
    chk_contend_quit: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (lk_ff.arb == ARB_CONTEND && inCh && mism
        && r >= `TDMCH_ADDR_FIRST && r <= `TDMCH_MON_LAST)
        |=> lk_ff.arb == ARB_IDLE ##1 !lk_ff.held)
        else $error("contention kept after address mismatch");
    chk_ci_double: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (inCh && r == `TDMCH_CI_LAST
        && ciCode != lk_ff.ciLast) |=> $stable(lk_ff.ciTgl))
        else $error("code accepted after a single frame");
    chk_release_bus: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (lk_ff.arb == ARB_HOLD && !busReqS && inCh
        && r == `TDMCH_BA_BIT) |=> lk_ff.arb == ARB_IDLE && lk_ff.lowPrio)
        else $error("bus kept after request withdrawn");
    chk_low_prio_wait: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (inCh && r == `TDMCH_BA_BIT && lk_ff.lowPrio
        && lk_ff.arb == ARB_IDLE) |=> lk_ff.arb != ARB_CONTEND)
        else $error("bus seized again before two free frames");
    chk_addr_idle: assert property (@(posedge linkDataClock)
        disable iff (lkRst) (inCh && r >= `TDMCH_ADDR_FIRST
        && r <= `TDMCH_MON_LAST && lk_ff.arb != ARB_CONTEND
        && lk_ff.ans != ANS_SEND) |-> !lk_ff.upOe)
        else $error("address bits driven without contention");
    chk_fx_refused: assert property (@(posedge ref_clk)
        disable iff (rst) (cmdValid && cmdReady
        && cmdKind == `TDMCH_CMD_ANSWER
        && cmdData[7:4] == `TDMCH_FX_NIBBLE)
        |=> cmdReject && $stable(us_ff.reqTgl))
        else $error("reserved answer byte not refused");
    chk_one_at_time: assert property (@(posedge ref_clk)
        disable iff (rst) (cmdValid && cmdReady && !(cmdKind
        == `TDMCH_CMD_ANSWER && cmdData[7:4] == `TDMCH_FX_NIBBLE))
        |=> !cmdReady [*2])
        else $error("second command taken before acknowledge");

    cov_bus_won: cover property (@(posedge linkDataClock)
        disable iff (lkRst) lk_ff.arb == ARB_CONTEND ##[1:3]
        lk_ff.arb == ARB_HOLD);
    cov_answer: cover property (@(posedge linkDataClock)
        disable iff (lkRst) lk_ff.ans == ANS_SEND);
    cov_ci_change: cover property (@(posedge ref_clk)
        disable iff (rst) ciChange);
    cov_reject: cover property (@(posedge ref_clk)
        disable iff (rst) cmdReject);

endmodule // tdmch_host

`default_nettype wire

// *** tb/tdmch_dev_model.sv ***
`default_nettype none

module tdmch_dev_model (
    // Link clock and reset
    input  wire logic       linkClk,
    input  wire logic       rst,
    // Far-side stimulus
    input  wire logic [3:0] ciCode,
    input  wire logic       stopBit,
    input  wire logic [7:0] peerMon,
    input  wire logic       peerELow,
    // Link pins
    input  wire logic       upOe,
    output logic            frameSync,
    output logic            downLine,
    output logic            upLine,
    // Observed upstream octets
    output logic [7:0]      upMon,
    output logic            upE
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0] cnt;
    logic [7:0] sh;
    logic       peerBit;

    // Three channels of 32 bits; only channel 0 carries traffic.
    always @(posedge linkClk) begin
        cnt <= (rst === 1'b1 || cnt == 7'd95) ? 7'd0 : cnt + 7'd1;
        sh <= {sh[6:0], upLine};
        if (rst === 1'b1) begin
            upMon <= 8'hff;
            upE <= 1'b1;
        end else if (cnt == 7'd23) begin
            upMon <= {sh[6:0], upLine};
        end else if (cnt == 7'd31) begin
            upE <= upLine;
        end
    end

    // Unused slots fall back to the pull-up level, never the last bit.
    always_comb begin
        peerBit = 1'b1;
        downLine = 1'b1;
        if (cnt >= 7'd16 && cnt <= 7'd23) begin
            peerBit = peerMon[~cnt[2:0]];
            downLine = (~cnt[2:0] == 3'h3) ? stopBit : 1'b1;
        end else if (cnt >= 7'd26 && cnt <= 7'd29) begin
            downLine = ciCode[2'(7'd29 - cnt)];
        end else if (cnt == 7'd31) begin
            peerBit = ~peerELow;
        end
        upLine = peerBit & ~upOe;
        frameSync = (cnt == 7'd95);
    end
endmodule // tdmch_dev_model

`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
`include "tdmch_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk = 1'b0, linkClk = 1'b0, rst = 1'b1;
    logic       cmdValid = 1'b0, busRequest = 1'b0, stopBit = 1'b1;
    logic       peerELow = 1'b0;
    logic [1:0] cmdKind = 2'h3;
    logic [7:0] cmdData = 8'h00, peerMon = 8'hff;
    logic [3:0] ciCode = 4'hf;
    logic       frameSync, downLine, upLine, upOe, upE, cmdReady, cmdReject;
    logic       busHeld, stopGo, ciChange, monRxValid, upOut;
    logic [3:0] ciRx;
    logic [7:0] monRx, upMon;
    int         bad_count = 0, check_count = 0, ciCnt = 0, monCnt = 0, n;
    // Each row: C/I code and stop bit, which ciRx and stopGo should echo.
    logic [4:0] rows [3] = '{5'h07, 5'h18, 5'h01};

    always #25 ref_clk = ~ref_clk;
    always #7.5 linkClk = ~linkClk;

    tdmch_host tdmch_host_i (.ref_clk(ref_clk), .rst(rst),
        .linkDataClock(linkClk), .frameSync(frameSync),
        .downstreamLine(downLine), .upstreamLineIn(upLine),
        .upstreamLineOut(upOut), .upstreamLineOe(upOe), .cmdValid(cmdValid),
        .cmdKind(cmdKind), .cmdData(cmdData), .cmdReady(cmdReady),
        .cmdReject(cmdReject), .busRequest(busRequest), .busHeld(busHeld),
        .stopGo(stopGo), .ciRx(ciRx), .ciChange(ciChange), .monRx(monRx),
        .monRxValid(monRxValid));
    tdmch_dev_model tdmch_dev_model_i (.linkClk(linkClk), .rst(rst),
        .ciCode(ciCode), .stopBit(stopBit), .peerMon(peerMon),
        .peerELow(peerELow), .upOe(upOe), .frameSync(frameSync),
        .downLine(downLine), .upLine(upLine), .upMon(upMon), .upE(upE));

    // Pulses last one cycle, so they are counted rather than polled.
    always @(negedge ref_clk) begin
        if (ciChange === 1'b1) ciCnt++;
        if (monRxValid === 1'b1) monCnt++;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic frames(input int k);
        repeat (k) @(posedge frameSync);
    endtask

    task automatic cmd(input logic [1:0] k, input logic [7:0] d);
        int i;
        @(negedge ref_clk);
        cmdValid = 1'b1;
        cmdKind = k;
        cmdData = d;
        i = 0;
        // Ready is looked at mid-cycle; the next rising edge takes the command.
        while (cmdReady !== 1'b1 && i < 400) begin
            @(negedge ref_clk);
            i++;
        end
        if (i >= 400) bad_count++;
        @(negedge ref_clk);
        cmdValid = 1'b0;
    endtask

    task automatic peerSend(input logic [7:0] b);
        @(posedge frameSync);
        peerELow = 1'b1;
        @(posedge frameSync);
        peerELow = 1'b0;
        peerMon = b;
        @(posedge frameSync);
        peerMon = 8'hff;
        frames(2);
    endtask

    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #300us;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("ciRx", 8'h0f, {4'h0, ciRx});
        chk("monRx", 8'hff, monRx);
        chk("cmdReady", 8'h00, {7'h0, cmdReady});
        chk("busHeld", 8'h00, {7'h0, busHeld});
        chk("upOut", 8'h00, {7'h0, upOut});
        rst = 1'b0;
        frames(3);
        chk("idle upMon", 8'hff, upMon);
        $display("TEST reset done");
        for (int r = 0; r < 3; r++) begin
            n = ciCnt;
            ciCode = rows[r][4:1];
            stopBit = rows[r][0];
            frames(4);
            chk("ciRx", {4'h0, rows[r][4:1]}, {4'h0, ciRx});
            chk("stopGo", {7'h0, rows[r][0]}, {7'h0, stopGo});
            chk("ciChange", 8'h01, 8'(ciCnt - n));
        end
        n = ciCnt;
        ciCode = 4'h5;
        frames(1);
        ciCode = 4'h0;
        frames(3);
        chk("single frame code", 8'h00, 8'(ciCnt - n));
        chk("ciRx", 8'h00, {4'h0, ciRx});
        $display("TEST command indicate done");
        cmd(`TDMCH_CMD_CFG, 8'h02);
        cmd(`TDMCH_CMD_ANSWER, 8'h5a);
        n = 0;
        while (upE !== 1'b0 && n < 10) begin
            frames(1);
            n++;
        end
        frames(1);
        chk("answer byte", 8'h5a, upMon);
        cmd(`TDMCH_CMD_ANSWER, 8'hf3);
        chk("cmdReject", 8'h01, {7'h0, cmdReject});
        n = monCnt;
        peerSend(8'h3c);
        chk("monRx", 8'h3c, monRx);
        peerSend(8'hf3);
        chk("monRx after Fx", 8'h3c, monRx);
        chk("monRxValid", 8'h01, 8'(monCnt - n));
        $display("TEST monitor done");
        @(negedge ref_clk);
        busRequest = 1'b1;
        peerMon = 8'hf9;
        frames(6);
        chk("busHeld lost", 8'h00, {7'h0, busHeld});
        peerMon = 8'hff;
        n = 0;
        while (busHeld !== 1'b1 && n < 10) begin
            frames(1);
            n++;
        end
        chk("busHeld", 8'h01, {7'h0, busHeld});
        frames(1);
        chk("accessed bit", 8'h00, {7'h0, upMon[3]});
        @(negedge ref_clk);
        busRequest = 1'b0;
        frames(4);
        chk("busHeld off", 8'h00, {7'h0, busHeld});
        chk("free upMon", 8'hff, upMon);
        $display("TEST arbitration done");
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
